// ### verilog/dwsc_pkg.sv
// Constants, codes and state types of the dual wiper serial control block.
// Assumes a 125 MHz system clock; serial pins arrive from another domain.
//
// Summary of operation
// R1 - Serial output changes on each falling serial clock edge during reads.
// R2 - Opcode, address and data bits are sampled on rising serial clock.
// R3 - Pause input low freezes the transfer; sequence state is kept.
// R4 - A host not using pause keeps the pause input high.
// R5 - Command proceeds only if the received slave address matches the straps.
// R6 - Chip select high deselects, output floats, standby unless NV busy.
// R7 - After power-up nothing runs until chip select has fallen once.
// R8 - Write-protect low blocks every nonvolatile setting write.
// R9 - Host holds select low, pause and write-protect high all operation.
// R10 - Each wiper value enables exactly one of its 256 tap switches.
// R11 - Wiper 00 hex selects low terminal, FF hex selects high terminal.
// R12 - Wiper changes by serial write, slot load, step, or power-up recall.
// R13 - At power-up each wiper loads from its default setting slot zero.
// R14 - Wiper position is volatile and rebuilt at each power-up.
// R15 - Each pot owns four 8-bit settings, readable, writable, exchangeable.
// R16 - A nonvolatile setting write completes within its maximum time.
// R17 - Busy flag reads 1 during a nonvolatile write cycle, else 0.
// R18 - First byte: upper nibble device type, lower nibble slave address.
// R19 - Instruction byte: two slot bits choose slot, bit zero chooses pot.
// R20 - Step mode: each clock moves wiper up if input high, else down.
// R21 - Stepping saturates at 0 and 255 instead of wrapping.
package dwsc_pkg;

  // Device type nibble; value is arbitrary
  localparam logic [3:0] DEV_TYPE_ID = 4'h9;

  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'ha;
  localparam logic [3:0] OP_RD_SLOT = 4'hb;
  localparam logic [3:0] OP_WR_SLOT = 4'hc;
  localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_SLOT = 4'he;
  localparam logic [3:0] OP_ALL_SLOT_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_ALL_WIPER_TO_SLOT = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_RD_FLAGS = 4'h5;

  // Instruction byte field positions
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 4;
  localparam int SLOT_HI_POS = 3;
  localparam int SLOT_LO_POS = 2;
  localparam int POT_SEL_POS = 0;

  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [7:0] WIPER_MAX = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] DEFAULT_SLOT = 2'h0;

  // Nonvolatile write time, longest figure rounded down to cycles
  localparam int CLK_KHZ = 125000;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLK_KHZ;
  localparam int BUSY_W = 21;

  typedef enum logic [8:0] {
    ST_RECALL = 9'h001,
    ST_ARMED  = 9'h002,
    ST_IDLE   = 9'h004,
    ST_ID     = 9'h008,
    ST_INSTR  = 9'h010,
    ST_WDATA  = 9'h020,
    ST_RDATA  = 9'h040,
    ST_STEP   = 9'h080,
    ST_SKIP   = 9'h100
  } dwsc_fsm_type;

endpackage : dwsc_pkg

// ### verilog/dwsc_tap_decode.sv
// Tap switch decoder for one resistor array.
// Assumes a registered wiper value at its input.
`timescale 1ns/1ps
module dwsc_tap_decode
(
  // Wiper value
  input wire logic [7:0] pos,
  // One enable per tap, index 0 at the low terminal
  output logic [255:0] tap_en
);

  genvar i;
  generate
    for (i = 0; i < 256; i++)
    begin : g_tap
      assign tap_en[i] = (pos == 8'(i)); // [R10] [R11]
    end
  endgenerate

endmodule : dwsc_tap_decode

// ### verilog/dwsc_core.sv
// Serial control core of a dual digitally controlled potentiometer.
// Assumes all serial pins and straps are asynchronous to clk; the
// serial clock is slower than clk / 8 so each edge is seen.
`timescale 1ns/1ps
module dwsc_core
#(
  parameter int unsigned NV_WRITE_CYCLES = dwsc_pkg::NV_WRITE_CYCLES
)
(
  // System
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  input wire logic sck,
  input wire logic si,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe_n,
  // Address straps
  input wire logic [1:0] addr_strap,
  // Potentiometer side
  output logic [1:0][255:0] tap_en,
  output logic nv_write_busy,
  output logic standby
);
  import dwsc_pkg::*;

  typedef struct packed {
    logic sck_m, sck_s, sck_d;
    logic si_m, si_s;
    logic cs_m, cs_s, cs_d;
    logic hold_m, hold_s;
    logic wp_m, wp_s;
    logic [1:0] strap_m, strap_s;
    dwsc_fsm_type state;
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [3:0] op;
    logic pot;
    logic [1:0] slot;
    logic [7:0] out_sr;
    logic so;
    logic drive;
    logic [1:0][7:0] wiper_position_reg;
    logic [1:0][3:0][7:0] stored_setting_reg;
    logic nv_pend, nv_glob, nv_pot;
    logic [1:0] nv_slot;
    logic [7:0] nv_data;
    logic busy;
    logic [BUSY_W-1:0] busy_cnt;
  } dwsc_state_type;

  localparam logic [BUSY_W-1:0] BUSY_LAST = BUSY_W'(NV_WRITE_CYCLES - 1);

  dwsc_state_type r_reg, r_next;
  logic link_on, rise, fall, cs_fall, cs_rise, byte_done;
  logic [7:0] byte_in;

  assign cs_fall = r_reg.cs_d & ~r_reg.cs_s;
  assign cs_rise = ~r_reg.cs_d & r_reg.cs_s;
  // Edges are ignored while paused; the host pauses only with sck low
  assign link_on = ~r_reg.cs_s & r_reg.hold_s; // [R3]
  assign rise = link_on & r_reg.sck_s & ~r_reg.sck_d; // [R2]
  assign fall = link_on & ~r_reg.sck_s & r_reg.sck_d; // [R1]
  assign byte_in = {r_reg.shift, r_reg.si_s};
  assign byte_done = rise & (r_reg.bit_cnt == 3'h7);

  always_comb
  begin
    r_next = r_reg;
    r_next.sck_m = sck;
    r_next.sck_s = r_reg.sck_m;
    r_next.sck_d = r_reg.sck_s;
    r_next.si_m = si;
    r_next.si_s = r_reg.si_m;
    r_next.cs_m = cs_n;
    r_next.cs_s = r_reg.cs_m;
    r_next.cs_d = r_reg.cs_s;
    r_next.hold_m = hold_n;
    r_next.hold_s = r_reg.hold_m;
    r_next.wp_m = wp_n;
    r_next.wp_s = r_reg.wp_m;
    r_next.strap_m = addr_strap;
    r_next.strap_s = r_reg.strap_m;

    if (r_reg.busy)
    begin
      if (r_reg.busy_cnt == BUSY_LAST)
      begin
        r_next.busy = 1'b0; // [R16] [R17]
      end
      else
      begin
        r_next.busy_cnt = r_reg.busy_cnt + 1'b1;
      end
    end

    if (rise)
    begin
      r_next.shift = byte_in[6:0]; // [R2]
      r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
    end

    unique case (r_reg.state)
      ST_RECALL:
      begin
        // Wipers are volatile and rebuilt from slot zero after reset
        for (int p = 0; p < 2; p++)
        begin
          r_next.wiper_position_reg[p] =
            r_reg.stored_setting_reg[p][DEFAULT_SLOT]; // [R13] [R14]
        end
        r_next.state = ST_ARMED;
      end
      ST_ARMED:
      begin
        if (cs_fall)
        begin
          r_next.state = ST_ID; // [R7]
          r_next.bit_cnt = 3'h0;
        end
      end
      ST_IDLE, ST_SKIP:
      begin
      end
      ST_ID:
      begin
        if (byte_done)
        begin
          if (byte_in[7:4] == DEV_TYPE_ID
              && byte_in[3:0] == {2'b00, r_reg.strap_s}) // [R5] [R18]
          begin
            r_next.state = ST_INSTR;
          end
          else
          begin
            r_next.state = ST_SKIP; // [R5]
          end
        end
      end
      ST_INSTR:
      begin
        if (byte_done)
        begin
          r_next.op = byte_in[OP_MSB:OP_LSB];
          r_next.slot = {byte_in[SLOT_HI_POS], byte_in[SLOT_LO_POS]}; // [R19]
          r_next.pot = byte_in[POT_SEL_POS]; // [R19]
          r_next.state = ST_SKIP;
          // Only the flag read is served while a NV cycle runs
          if (!r_reg.busy || byte_in[OP_MSB:OP_LSB] == OP_RD_FLAGS)
          begin
            unique case (byte_in[OP_MSB:OP_LSB])
              OP_RD_WIPER:
              begin
                r_next.out_sr =
                  r_reg.wiper_position_reg[byte_in[POT_SEL_POS]];
                r_next.state = ST_RDATA;
              end
              OP_RD_SLOT:
              begin
                r_next.out_sr = r_reg.stored_setting_reg
                  [byte_in[POT_SEL_POS]][r_next.slot]; // [R15]
                r_next.state = ST_RDATA;
              end
              OP_RD_FLAGS:
              begin
                r_next.out_sr = {7'h00, r_reg.busy}; // [R17]
                r_next.state = ST_RDATA;
              end
              OP_WR_WIPER, OP_WR_SLOT:
              begin
                r_next.state = ST_WDATA;
              end
              OP_SLOT_TO_WIPER:
              begin
                r_next.wiper_position_reg[byte_in[POT_SEL_POS]] =
                  r_reg.stored_setting_reg
                  [byte_in[POT_SEL_POS]][r_next.slot]; // [R12]
              end
              OP_ALL_SLOT_TO_WIPER:
              begin
                for (int p = 0; p < 2; p++)
                begin
                  r_next.wiper_position_reg[p] =
                    r_reg.stored_setting_reg[p][r_next.slot]; // [R12]
                end
              end
              OP_WIPER_TO_SLOT, OP_ALL_WIPER_TO_SLOT:
              begin
                r_next.nv_pend = 1'b1; // [R15]
                r_next.nv_glob =
                  (byte_in[OP_MSB:OP_LSB] == OP_ALL_WIPER_TO_SLOT);
                r_next.nv_pot = byte_in[POT_SEL_POS];
                r_next.nv_slot = r_next.slot;
                r_next.nv_data =
                  r_reg.wiper_position_reg[byte_in[POT_SEL_POS]];
              end
              OP_STEP:
              begin
                r_next.state = ST_STEP;
              end
              default:
              begin
              end
            endcase
          end
        end
      end
      ST_WDATA:
      begin
        if (byte_done)
        begin
          r_next.state = ST_SKIP;
          if (r_reg.op == OP_WR_WIPER)
          begin
            r_next.wiper_position_reg[r_reg.pot] = byte_in; // [R12]
          end
          else
          begin
            r_next.nv_pend = 1'b1; // [R15]
            r_next.nv_glob = 1'b0;
            r_next.nv_pot = r_reg.pot;
            r_next.nv_slot = r_reg.slot;
            r_next.nv_data = byte_in;
          end
        end
      end
      ST_RDATA:
      begin
        if (fall)
        begin
          r_next.so = r_reg.out_sr[7]; // [R1]
          r_next.out_sr = {r_reg.out_sr[6:0], 1'b0};
        end
        if (byte_done)
        begin
          r_next.state = ST_SKIP;
        end
      end
      ST_STEP:
      begin
        if (rise)
        begin
          // Saturate at the ends rather than wrap
          if (r_reg.si_s
              && r_reg.wiper_position_reg[r_reg.pot] != WIPER_MAX) // [R21]
          begin
            r_next.wiper_position_reg[r_reg.pot] =
              r_reg.wiper_position_reg[r_reg.pot] + 8'h01; // [R20]
          end
          else if (!r_reg.si_s
              && r_reg.wiper_position_reg[r_reg.pot] != WIPER_MIN) // [R21]
          begin
            r_next.wiper_position_reg[r_reg.pot] =
              r_reg.wiper_position_reg[r_reg.pot] - 8'h01; // [R20]
          end
        end
      end
    endcase

    if (r_reg.state != ST_RECALL && r_reg.state != ST_ARMED)
    begin
      if (cs_fall)
      begin
        r_next.state = ST_ID;
        r_next.bit_cnt = 3'h0;
        r_next.nv_pend = 1'b0;
      end
      else if (cs_rise)
      begin
        r_next.state = ST_IDLE; // [R6]
        r_next.nv_pend = 1'b0;
        // NV writes commit only on deselect, and only if unprotected
        if (r_reg.nv_pend && r_reg.wp_s) // [R8]
        begin
          for (int p = 0; p < 2; p++)
          begin
            if (r_reg.nv_glob)
            begin
              r_next.stored_setting_reg[p][r_reg.nv_slot] =
                r_reg.wiper_position_reg[p];
            end
            else if (r_reg.nv_pot == 1'(p))
            begin
              r_next.stored_setting_reg[p][r_reg.nv_slot] = r_reg.nv_data;
            end
          end
          r_next.busy = 1'b1; // [R17]
          r_next.busy_cnt = '0;
        end
      end
    end
    r_next.drive = (r_next.state == ST_RDATA) && !r_reg.cs_s; // [R6]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_reg <= '{state: ST_RECALL, hold_m: 1'b1, hold_s: 1'b1,
                 wp_m: 1'b1, wp_s: 1'b1, default: '0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pot
      dwsc_tap_decode u_dec (
        .pos (r_reg.wiper_position_reg[g]),
        .tap_en (tap_en[g])
      );
    end
  endgenerate

  assign so_o = r_reg.so;
  assign so_oe_n = ~r_reg.drive;
  assign nv_write_busy = r_reg.busy;
  assign standby = r_reg.cs_s & ~r_reg.busy; // [R6]

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_SO_ON_FALL: assert property ( // [R1]
    $changed(r_reg.so) |-> $past(fall))
    else $error("serial output moved without a falling edge");
  AST_SAMPLE_RISE: assert property ( // [R2]
    rise |=> r_reg.shift[0] == $past(r_reg.si_s))
    else $error("input bit not sampled on rising edge");
  AST_PAUSE_KEEPS: assert property ( // [R3]
    !r_reg.hold_s && !cs_fall |=> $stable(r_reg.bit_cnt)
      && $stable(r_reg.shift))
    else $error("sequence moved while paused");
  AST_ADDR_MISS: assert property ( // [R5]
    r_reg.state == ST_ID && byte_done && !cs_fall && !cs_rise
      && byte_in[3:0] != {2'b00, r_reg.strap_s} |=> r_reg.state == ST_SKIP)
    else $error("mismatched address not ignored");
  AST_DESELECT_FLOAT: assert property ( // [R6]
    r_reg.cs_s |=> so_oe_n)
    else $error("output driven while deselected");
  AST_ARMED_WAIT: assert property ( // [R7]
    r_reg.state == ST_ARMED && !cs_fall |=> r_reg.state == ST_ARMED)
    else $error("left armed state without select falling");
  AST_WP_BLOCK: assert property ( // [R8]
    cs_rise && !r_reg.wp_s |=> $stable(r_reg.stored_setting_reg)
      && !$rose(r_reg.busy))
    else $error("protected nonvolatile write happened");
  AST_ONE_TAP: assert property ( // [R10]
    $onehot(tap_en[0]) && $onehot(tap_en[1]))
    else $error("tap enables not one-hot");
  AST_LOW_END: assert property ( // [R11]
    r_reg.wiper_position_reg[0] == WIPER_MIN |-> tap_en[0][0])
    else $error("zero wiper not at low terminal");
  AST_RECALL: assert property ( // [R13]
    r_reg.state == ST_RECALL |=> r_reg.wiper_position_reg[1]
      == $past(r_reg.stored_setting_reg[1][DEFAULT_SLOT]))
    else $error("power-up recall missed");
  AST_BUSY_BOUND: assert property ( // [R16]
    r_reg.busy && r_reg.busy_cnt == BUSY_LAST |=> !r_reg.busy)
    else $error("nonvolatile write overran its time");
  AST_SAT_TOP: assert property ( // [R21]
    r_reg.state == ST_STEP && rise && r_reg.si_s && !cs_fall
      && r_reg.wiper_position_reg[r_reg.pot] == WIPER_MAX
      |=> r_reg.wiper_position_reg[$past(r_reg.pot)] == WIPER_MAX)
    else $error("wiper wrapped above top");

  COV_READ: cover property (r_reg.state == ST_RDATA && byte_done);
  COV_STEP: cover property (r_reg.state == ST_STEP && rise);
  COV_NV: cover property ($rose(r_reg.busy));
  COV_MISS: cover property (r_reg.state == ST_ID ##1 r_reg.state == ST_SKIP);

endmodule : dwsc_core

// ### tb/dwsc_host.sv
// Host side model of the serial link of the dual wiper control block.
// Assumes clk is the block's system clock; the link moves on clk falls.
`timescale 1ns/1ps
module dwsc_host
(
  // System
  input wire logic clk,
  // Serial link
  output logic sck,
  output logic si,
  output logic cs_n,
  output logic hold_n,
  output logic wp_n,
  input wire logic so_o,
  input wire logic so_oe_n
);
  // Half of the 160 ns serial period in clk cycles
  localparam int HALF = 10;
  logic so_last = 1'b0;
  logic so_line;

  // A released output shows the inverse of its last level, not a hold
  always @(posedge clk)
    if (!so_oe_n)
      so_last <= so_o;
  assign so_line = so_oe_n ? ~so_last : so_o;

  initial
  begin
    sck = 1'b0;
    si = 1'b0;
    cs_n = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic bit_x(input logic b, output logic r);
    si = b;
    idle(HALF);
    r = so_line;
    sck = 1'b1;
    idle(HALF);
    sck = 1'b0;
  endtask : bit_x

  task automatic byte_x(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], r[i]);
  endtask : byte_x

  // Clock pulses sent while paused must leave the sequence untouched
  task automatic pause();
    logic junk;
    idle(2);
    hold_n = 1'b0;
    bit_x(1'b1, junk);
    bit_x(1'b0, junk);
    // Let the last low clock settle before resuming, so no edge slips in
    idle(3);
    hold_n = 1'b1;
    idle(HALF);
  endtask : pause

  task automatic start();
    cs_n = 1'b0;
    idle(HALF);
  endtask : start

  task automatic stop();
    cs_n = 1'b1;
    idle(HALF);
  endtask : stop

endmodule : dwsc_host

// ### tb/dual_wiper_serial_control_tb.sv
// Self-checking bench of the dual wiper serial control core.
// Assumes the host model drives the link; straps are set to STRAP.
`timescale 1ns/1ps
module dual_wiper_serial_control_tb;
  import dwsc_pkg::*;
  // Short write cycle keeps the run brief
  localparam int NV_CYC = 1000;
  localparam logic [1:0] STRAP = 2'h1;
  localparam logic [7:0] PAUSE_VAL = 8'h5a;
  logic clk, nrst, sck, si, cs_n, hold_n, wp_n, so_o, so_oe_n;
  logic [1:0] addr_strap;
  logic [1:0][255:0] tap_en;
  logic nv_write_busy, standby;
  logic [7:0] id_byte, r;
  int miscompares, tests_run, cycles;

  dwsc_core #(.NV_WRITE_CYCLES(NV_CYC)) dwsc_core_inst (.clk(clk),
    .nrst(nrst), .sck(sck), .si(si), .cs_n(cs_n), .hold_n(hold_n),
    .wp_n(wp_n), .so_o(so_o), .so_oe_n(so_oe_n), .addr_strap(addr_strap),
    .tap_en(tap_en), .nv_write_busy(nv_write_busy), .standby(standby));

  dwsc_host dwsc_host_inst (.clk(clk), .sck(sck), .si(si), .cs_n(cs_n),
    .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe_n(so_oe_n));

  task automatic results();
    $display("Compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // nb is 1 for instruction only, 2 when a data byte follows
  task automatic cmd(input logic [3:0] op, input logic [1:0] slot,
    input logic pot, input logic [7:0] d, input int nb);
    logic [7:0] junk;
    r = 8'h00;
    dwsc_host_inst.start();
    dwsc_host_inst.byte_x(id_byte, junk);
    dwsc_host_inst.byte_x({op, slot, 1'b0, pot}, junk);
    if (nb > 1)
      dwsc_host_inst.byte_x(d, r);
    dwsc_host_inst.stop();
  endtask : cmd

  task automatic nv_wait(input bit rd_flags);
    int n;
    n = 0;
    check(nv_write_busy, 1'b1);
    check(standby, 1'b0);
    if (rd_flags)
    begin
      cmd(OP_RD_FLAGS, 2'h0, 1'b0, 8'h00, 2);
      check(r, 8'h01);
    end
    while (nv_write_busy === 1'b1 && n < NV_CYC + 50)
    begin
      @(negedge clk);
      n++;
    end
    check(n < NV_CYC, 1'b1);
    check(standby, 1'b1);
  endtask : nv_wait

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    nrst = 1'b0;
    addr_strap = STRAP;
    id_byte = {DEV_TYPE_ID, 2'h0, STRAP};
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    dwsc_host_inst.idle(4);
    check(tap_en[0], 256'h1);
    check(tap_en[1], 256'h1);
    check(so_oe_n, 1'b1);
    // Select was low through reset, so no falling edge has been seen
    dwsc_host_inst.byte_x(id_byte, r);
    dwsc_host_inst.byte_x({OP_WR_WIPER, 4'h0}, r);
    dwsc_host_inst.byte_x(8'h33, r);
    dwsc_host_inst.stop();
    check(tap_en[0], 256'h1);
    cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'hff, 2);
    check(tap_en[0], 256'h1 << 255);
    dwsc_host_inst.start();
    dwsc_host_inst.byte_x(id_byte, r);
    dwsc_host_inst.byte_x({OP_WR_WIPER, 4'h1}, r);
    for (int i = 7; i >= 0; i--)
    begin
      if (i == 3)
        dwsc_host_inst.pause();
      dwsc_host_inst.bit_x(PAUSE_VAL[i], r[0]);
    end
    dwsc_host_inst.stop();
    check(tap_en[1], 256'h1 << 8'h5a);
    check(tap_en[0], 256'h1 << 255);
    cmd(OP_RD_WIPER, 2'h0, 1'b1, 8'h00, 2);
    check(r, 8'h5a);
    check(so_oe_n, 1'b1);
    id_byte = {DEV_TYPE_ID, 2'h0, ~STRAP};
    cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h11, 2);
    check(tap_en[1], 256'h1 << 8'h5a);
    id_byte = {~DEV_TYPE_ID, 2'h0, STRAP};
    cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h11, 2);
    check(tap_en[1], 256'h1 << 8'h5a);
    id_byte = {DEV_TYPE_ID, 2'h0, STRAP};
    cmd(OP_WR_SLOT, 2'h3, 1'b1, 8'h3c, 2);
    nv_wait(1'b1);
    cmd(OP_RD_FLAGS, 2'h0, 1'b0, 8'h00, 2);
    check(r, 8'h00);
    dwsc_host_inst.wp_n = 1'b0;
    cmd(OP_WR_SLOT, 2'h1, 1'b0, 8'h77, 2);
    dwsc_host_inst.wp_n = 1'b1;
    check(nv_write_busy, 1'b0);
    cmd(OP_RD_SLOT, 2'h1, 1'b0, 8'h00, 2);
    check(r, 8'h00);
    cmd(OP_RD_SLOT, 2'h3, 1'b1, 8'h00, 2);
    check(r, 8'h3c);
    cmd(OP_SLOT_TO_WIPER, 2'h3, 1'b1, 8'h00, 1);
    check(tap_en[1], 256'h1 << 8'h3c);
    cmd(OP_WIPER_TO_SLOT, 2'h2, 1'b0, 8'h00, 1);
    nv_wait(1'b0);
    cmd(OP_RD_SLOT, 2'h2, 1'b0, 8'h00, 2);
    check(r, 8'hff);
    cmd(OP_ALL_WIPER_TO_SLOT, 2'h1, 1'b0, 8'h00, 1);
    nv_wait(1'b0);
    cmd(OP_RD_SLOT, 2'h1, 1'b1, 8'h00, 2);
    check(r, 8'h3c);
    cmd(OP_ALL_SLOT_TO_WIPER, 2'h0, 1'b0, 8'h00, 1);
    check(tap_en[0], 256'h1);
    check(tap_en[1], 256'h1);
    // Five steps down stick at zero, three up follow
    cmd(OP_STEP, 2'h0, 1'b0, 8'h07, 2);
    check(tap_en[0], 256'h1 << 3);
    cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'hfd, 2);
    cmd(OP_STEP, 2'h0, 1'b1, 8'hff, 2);
    check(tap_en[1], 256'h1 << 255);
    nrst = 1'b0;
    dwsc_host_inst.idle(3);
    nrst = 1'b1;
    dwsc_host_inst.idle(4);
    check(tap_en[0], 256'h1);
    check(tap_en[1], 256'h1);
    results();
  end

endmodule : dual_wiper_serial_control_tb
